// [rtl/drb_buf.sv]
// Purpose: one reply buffer memory with its address registers and reply counter
// Assumes: strobes come from logic on mclk; clr is the synchronous bus I/O reset
// Notes: read data is combinational from the read address; the caller registers it
module drb_buf import drb_pkg::*; #(
  parameter int DW = DRB_DW,
  parameter int AW = DRB_AW,
  parameter int CW = DRB_CW
) (
  input logic mclk,
  input logic rst_n,
  input logic clr,
  input logic wr_en,
  input logic [DW-1:0] wdata,
  input logic rd_en,
  output logic [DW-1:0] rdata,
  input logic inc,
  input logic dec,
  output logic [CW-1:0] count
);
  localparam logic [AW-1:0] ADDR_TOP = {AW{1'b1}};

  logic [DW-1:0] mem_q [0:(1<<AW)-1];
  logic [AW-1:0] waddr_reg;
  logic [AW-1:0] waddr_next;
  logic [AW-1:0] raddr_reg;
  logic [AW-1:0] raddr_next;
  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;

  // ==================================================================
  // storage
  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem_q[waddr_reg] <= wdata;
    end
  end
  assign rdata = mem_q[raddr_reg];
  assign count = count_reg;

  // ==================================================================
  // address and counter update; io reset beats any same-cycle access
  assign waddr_next = clr ? '0 : !wr_en ? waddr_reg :
                      (waddr_reg == ADDR_TOP) ? '0 : waddr_reg + 1'b1;
  assign raddr_next = clr ? '0 : !rd_en ? raddr_reg :
                      (raddr_reg == ADDR_TOP) ? '0 : raddr_reg + 1'b1;
  // underflow is held at zero so a stray take cannot fake a full counter
  assign count_next = clr ? '0 :
                      (inc && !dec) ? count_reg + 1'b1 :
                      (dec && !inc && count_reg != '0) ? count_reg - 1'b1 :
                      count_reg;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      waddr_reg <= '0;
      raddr_reg <= '0;
      count_reg <= '0;
    end else begin
      waddr_reg <= waddr_next;
      raddr_reg <= raddr_next;
      count_reg <= count_next;
    end
  end

  // ==================================================================
  // checks
  wr_wrap_a: assert property (@(posedge mclk) disable iff (!rst_n)
    wr_en && !clr && waddr_reg == ADDR_TOP |=> waddr_reg == '0)
    else $error("write address did not wrap");
  rd_wrap_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rd_en && !clr && raddr_reg == ADDR_TOP |=> raddr_reg == '0)
    else $error("read address did not wrap");
  wr_advance_a: assert property (@(posedge mclk) disable iff (!rst_n)
    wr_en && !clr && waddr_reg != ADDR_TOP |=> waddr_reg == $past(waddr_reg) + 1'b1)
    else $error("write address did not advance");
  io_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
    clr |=> waddr_reg == '0 && raddr_reg == '0 && count_reg == '0)
    else $error("io reset left state behind");
  count_inc_a: assert property (@(posedge mclk) disable iff (!rst_n)
    inc && !dec && !clr |=> count_reg == $past(count_reg) + 1'b1)
    else $error("reply counter did not count");
endmodule

// [rtl/drb_host_port.sv]
// Purpose: host programmed-I/O port of a dual reply buffer reply generator
// Assumes: host bus and far-side controller are synchronous to mclk
// Notes: device code match is required for every instruction; no interrupt logic
// ==================================================================
module drb_host_port import drb_pkg::*; #(
  parameter int DW = DRB_DW,
  parameter int AW = DRB_AW,
  parameter int CW = DRB_CW
) (
  input logic mclk,
  input logic rst_n,
  input logic bus_io_reset,
  input logic [5:0] dev_code,
  input logic [1:0] host_port,
  input logic host_wr,
  input logic host_rd,
  input logic host_p,
  input logic [DW-1:0] host_wdata,
  output logic [DW-1:0] host_rdata_reg,
  input logic ctl_rd,
  input logic ctl_mem,
  input logic ctl_reply_take,
  input logic ctl_tr_done,
  output logic [DW-1:0] ctl_rdata_reg,
  output logic ctl_rvalid_reg,
  output logic ctl_reinit_reg,
  output logic target_reset_reg,
  output logic pri_sel_reg,
  output logic [CW-1:0] ctl_count_0,
  output logic [CW-1:0] ctl_count_1
);

  // ==================================================================
  // decode helpers
  function automatic logic fn_op(input logic hit, input logic strobe,
                                 input logic [1:0] port, input drb_port_t want);
    fn_op = hit && strobe && (port == want);
  endfunction

  // a physical memory takes the primary role when the swap bit names it
  function automatic logic fn_role(input logic ps, input logic idx,
                                   input logic pri_hit, input logic sec_hit);
    fn_role = (ps == idx) ? pri_hit : sec_hit;
  endfunction

  // ==================================================================
  // control state
  logic diag_reg;
  logic view_reg;
  logic tr_next;
  logic ps_next;
  logic diag_next;
  logic view_next;
  logic [DW-1:0] host_rdata_next;
  logic [DW-1:0] ctl_rdata_next;
  logic ctl_rvalid_next;

  // ==================================================================
  // instruction decode
  logic dev_hit;
  logic pbr;
  logic sbr;
  logic str;
  logic pbw;
  logic sbw;
  logic cw;
  logic buf_rd;

  // no start or clear input exists, so busy and done never come to be
  assign dev_hit = (dev_code == DRB_DEV_CODE);
  assign pbr = fn_op(dev_hit, host_rd, host_port, DRB_PORT_A);
  assign sbr = fn_op(dev_hit, host_rd, host_port, DRB_PORT_B);
  assign str = fn_op(dev_hit, host_rd, host_port, DRB_PORT_C);
  assign pbw = fn_op(dev_hit, host_wr, host_port, DRB_PORT_A);
  assign sbw = fn_op(dev_hit, host_wr, host_port, DRB_PORT_B);
  assign cw = fn_op(dev_hit, host_wr, host_port, DRB_PORT_C);
  assign buf_rd = pbr || sbr;

  // ==================================================================
  // buffer memories
  logic [1:0] wr_en;
  logic [1:0] rd_en;
  logic [1:0] host_take;
  logic [1:0] ctl_take;
  logic [1:0] inc;
  logic [1:0] dec;
  logic [DW-1:0] buf_rdata [0:1];
  logic [CW-1:0] buf_count [0:1];

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_buf
      localparam logic MEM_IDX = (gi == 1);
      // role follows the swap bit in the same cycle it changes
      assign wr_en[gi] = fn_role(pri_sel_reg, MEM_IDX, pbw, sbw);
      // host buffer reads move the pointer only in diagnostic mode
      assign host_take[gi] = diag_reg && fn_role(pri_sel_reg, MEM_IDX, pbr, sbr);
      // the host wins a same-cycle read of one memory; the controller read gets no ctl_rvalid_reg
      assign ctl_take[gi] = ctl_rd && (ctl_mem == MEM_IDX) && !host_take[gi];
      assign rd_en[gi] = host_take[gi] || ctl_take[gi];
      // P counts a reply only when it comes with a buffer write; wr_en gates it
      assign inc[gi] = wr_en[gi] && host_p;
      assign dec[gi] = ctl_reply_take && (ctl_mem == MEM_IDX);

      drb_buf #(
        .DW(DW),
        .AW(AW),
        .CW(CW)
      ) u_buf (
        .mclk(mclk),
        .rst_n(rst_n),
        .clr(bus_io_reset),
        .wr_en(wr_en[gi]),
        .wdata(host_wdata),
        .rd_en(rd_en[gi]),
        .rdata(buf_rdata[gi]),
        .inc(inc[gi]),
        .dec(dec[gi]),
        .count(buf_count[gi])
      );
    end
  endgenerate

  assign ctl_count_0 = buf_count[0];
  assign ctl_count_1 = buf_count[1];

  // ==================================================================
  // read selection
  logic [DW-1:0] pri_rdata;
  logic [DW-1:0] sec_rdata;
  logic [CW-1:0] count_view;
  logic [DW-1:0] status_word;
  logic [3:0] ctrl_word;

  assign pri_rdata = buf_rdata[pri_sel_reg];
  assign sec_rdata = buf_rdata[~pri_sel_reg];
  assign count_view = view_reg ? buf_count[~pri_sel_reg] : buf_count[pri_sel_reg];

  always_comb begin
    status_word = DRB_WORD_RST;
    status_word[DRB_BIT_TR] = target_reset_reg;
    status_word[DRB_BIT_PS] = pri_sel_reg;
    status_word[DRB_BIT_D] = diag_reg;
    status_word[DRB_BIT_RC] = view_reg;
    status_word[DRB_CNT_LSB +: CW] = count_view;
  end

  assign ctrl_word = {host_wdata[DRB_BIT_TR], host_wdata[DRB_BIT_PS],
                      host_wdata[DRB_BIT_D], host_wdata[DRB_BIT_RC]};

  // normal mode buffer reads return zero; the data word stands one cycle only
  assign host_rdata_next = (pbr && diag_reg) ? pri_rdata :
                           (sbr && diag_reg) ? sec_rdata :
                           str ? status_word :
                           DRB_WORD_RST;

  assign ctl_rdata_next = ctl_take[ctl_mem] ? buf_rdata[ctl_mem] : DRB_WORD_RST;
  assign ctl_rvalid_next = ctl_take[ctl_mem];

  // ==================================================================
  // control bits
  // a control write setting target reset wins over a same-cycle done
  assign tr_next = cw ? ctrl_word[3] :
                   ctl_tr_done ? DRB_CTRL_RST : target_reset_reg;
  assign ps_next = cw ? ctrl_word[2] : pri_sel_reg;
  assign diag_next = cw ? ctrl_word[1] : diag_reg;
  assign view_next = cw ? ctrl_word[0] : view_reg;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      target_reset_reg <= DRB_CTRL_RST;
      pri_sel_reg <= DRB_CTRL_RST;
      diag_reg <= DRB_CTRL_RST;
      view_reg <= DRB_CTRL_RST;
    end else begin
      target_reset_reg <= tr_next;
      pri_sel_reg <= ps_next;
      diag_reg <= diag_next;
      view_reg <= view_next;
    end
  end

  // ==================================================================
  // output registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      host_rdata_reg <= DRB_WORD_RST;
      ctl_rdata_reg <= DRB_WORD_RST;
      ctl_rvalid_reg <= DRB_CTRL_RST;
      ctl_reinit_reg <= DRB_CTRL_RST;
    end else begin
      host_rdata_reg <= host_rdata_next;
      ctl_rdata_reg <= ctl_rdata_next;
      ctl_rvalid_reg <= ctl_rvalid_next;
      ctl_reinit_reg <= bus_io_reset;
    end
  end

  // ==================================================================
  // checks
  dev_ignore_a: assert property (@(posedge mclk) disable iff (!rst_n)
    host_rd && !dev_hit |=> host_rdata_reg == DRB_WORD_RST)
    else $error("foreign device code was answered");

  normal_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
    buf_rd && !diag_reg |=> host_rdata_reg == DRB_WORD_RST)
    else $error("buffer data leaked in normal mode");

  pri_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
    pbr && diag_reg |=> host_rdata_reg == $past(pri_rdata))
    else $error("primary read returned wrong word");

  sec_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
    sbr && diag_reg |=> host_rdata_reg == $past(sec_rdata))
    else $error("secondary read returned wrong word");

  status_view_a: assert property (@(posedge mclk) disable iff (!rst_n)
    str |=> host_rdata_reg[CW-1:0] == $past(count_view))
    else $error("status showed wrong reply counter");

  read_once_a: assert property (@(posedge mclk) disable iff (!rst_n)
    str ##1 !host_rd |=> host_rdata_reg == DRB_WORD_RST)
    else $error("read data stood too long");

  ctrl_load_a: assert property (@(posedge mclk) disable iff (!rst_n)
    cw |=> {target_reset_reg, pri_sel_reg, diag_reg, view_reg} == $past(ctrl_word))
    else $error("control write not loaded");

  tr_done_a: assert property (@(posedge mclk) disable iff (!rst_n)
    target_reset_reg && ctl_tr_done && !cw |=> !target_reset_reg)
    else $error("target reset not cleared on done");

  tr_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    target_reset_reg && !ctl_tr_done && !cw |=> target_reset_reg)
    else $error("target reset dropped early");

  reinit_a: assert property (@(posedge mclk) disable iff (!rst_n)
    bus_io_reset |=> ctl_reinit_reg)
    else $error("controller not told to reinitialize");

  swap_wr_a: assert property (@(posedge mclk) disable iff (!rst_n)
    pbw |-> wr_en[pri_sel_reg] && !wr_en[~pri_sel_reg])
    else $error("primary write hit wrong memory");

  sec_wr_a: assert property (@(posedge mclk) disable iff (!rst_n)
    sbw |-> wr_en[~pri_sel_reg] && !wr_en[pri_sel_reg])
    else $error("secondary write hit wrong memory");

  idle_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !host_rd |=> host_rdata_reg == DRB_WORD_RST)
    else $error("read data without a read");

  status_bits_a: assert property (@(posedge mclk) disable iff (!rst_n)
    str |=> host_rdata_reg[DW-1:CW] == $past({target_reset_reg, pri_sel_reg, diag_reg, view_reg}))
    else $error("status control bits wrong");

  foreign_wr_a: assert property (@(posedge mclk) disable iff (!rst_n)
    host_wr && !dev_hit |-> wr_en == 2'b00 && inc == 2'b00)
    else $error("foreign write reached a buffer");

  normal_take_a: assert property (@(posedge mclk) disable iff (!rst_n)
    buf_rd && !diag_reg |-> host_take == 2'b00)
    else $error("normal mode read moved a pointer");

  ctrl_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !cw && !ctl_tr_done |=> {target_reset_reg, pri_sel_reg, diag_reg, view_reg} ==
      $past({target_reset_reg, pri_sel_reg, diag_reg, view_reg}))
    else $error("control bits changed without a write");

  reinit_once_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !bus_io_reset |=> !ctl_reinit_reg)
    else $error("reinit request without io reset");

  // ==================================================================
  // controller port checks
  ctl_serve_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ctl_rd && !host_take[ctl_mem] |=> ctl_rvalid_reg && ctl_rdata_reg == $past(buf_rdata[ctl_mem]))
    else $error("controller read not served");

  ctl_refuse_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ctl_rd && host_take[ctl_mem] |=> !ctl_rvalid_reg)
    else $error("controller read beat the host");

  swap_view_a: assert property (@(posedge mclk) disable iff (!rst_n)
    str && !view_reg |=> host_rdata_reg[CW-1:0] == $past(buf_count[pri_sel_reg]))
    else $error("status counter not the primary one");

endmodule

// [rtl/drb_pkg.sv]
// Purpose: shared constants for the dual reply buffer host port
// Assumes: 16-bit host words, two buffer memories of 1024 words each
// Notes: vector bit 15 is the high order bit (bit 0 as the host numbers it)
package drb_pkg;
  // ==================================================================
  // sizes
  localparam int DRB_DW = 16;
  localparam int DRB_AW = 10;
  localparam int DRB_CW = 12;
  // ==================================================================
  // device code, 46 octal
  localparam logic [5:0] DRB_DEV_CODE = 6'h26;
  // ==================================================================
  // host bit 0 (msb) sits at vector bit 15
  localparam int DRB_BIT_TR = 15;
  localparam int DRB_BIT_PS = 14;
  localparam int DRB_BIT_D = 13;
  localparam int DRB_BIT_RC = 12;
  localparam int DRB_CNT_LSB = 0;
  // ==================================================================
  // reset values
  localparam logic DRB_CTRL_RST = 1'h0;
  localparam logic [15:0] DRB_WORD_RST = 16'h0000;
  // ==================================================================
  // programmed-I/O register selector
  typedef enum logic [1:0] {
    DRB_PORT_NONE = 2'b00,
    DRB_PORT_A = 2'b01,
    DRB_PORT_B = 2'b10,
    DRB_PORT_C = 2'b11
  } drb_port_t;
endpackage

// [sim/drb_ctl_model.sv]
// Purpose: behavioural far-side controller that consumes the reply buffers
// Assumes: synchronous to mclk; requests come from the bench one cycle long, three in the host-wins case
// Notes: tr_lat sets how many cycles a target reset takes, zero is prompt
module drb_ctl_model (
  input logic mclk,
  input logic rst_n,
  input logic target_reset_reg,
  input logic ctl_reinit_reg,
  input logic [7:0] tr_lat,
  input logic take_req,
  input logic take_mem,
  output logic ctl_rd,
  output logic ctl_mem,
  output logic ctl_reply_take,
  output logic ctl_tr_done,
  output logic [3:0] reinit_seen
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] wait_cnt;
  // ==================================================================
  // consume replies, finish target resets, follow reinit requests
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_rd <= 1'b0;
      ctl_mem <= 1'b0;
      ctl_reply_take <= 1'b0;
      ctl_tr_done <= 1'b0;
      wait_cnt <= 8'h00;
      reinit_seen <= 4'h0;
    end else begin
      ctl_rd <= take_req;
      ctl_reply_take <= take_req;
      // an idle select line toggles so a stale value is never trusted
      ctl_mem <= take_req ? take_mem : ~ctl_mem;
      ctl_tr_done <= 1'b0;
      if (ctl_reinit_reg) begin
        reinit_seen <= reinit_seen + 4'h1;
        wait_cnt <= 8'h00;
      end else if (target_reset_reg && !ctl_tr_done) begin
        if (wait_cnt == tr_lat) begin
          ctl_tr_done <= 1'b1;
          wait_cnt <= 8'h00;
        end else begin
          wait_cnt <= wait_cnt + 8'h01;
        end
      end
    end
  end
endmodule

// [sim/tb_dual_reply_buffer_host_port.sv]
// Purpose: self-checking bench for the dual reply buffer host port
// Assumes: host instructions are spaced one idle cycle apart
// Notes: ordinary transfers run from a row table, edge cases by hand
module tb_dual_reply_buffer_host_port;
  timeunit 1ns;
  timeprecision 100ps;
  import drb_pkg::*;
  typedef struct packed {logic wr; logic [1:0] port; logic [15:0] d; logic p; logic [15:0] exp;} drb_row_t;
  logic mclk, rst_n, bus_io_reset, host_wr, host_rd, host_p, take_req, take_mem;
  logic [5:0] dev_code;
  logic [1:0] host_port;
  logic [15:0] host_wdata, host_rdata_reg, ctl_rdata_reg, q;
  logic ctl_rd, ctl_mem, ctl_reply_take, ctl_tr_done, ctl_rvalid_reg, ctl_reinit_reg;
  logic target_reset_reg, pri_sel_reg, done;
  logic [11:0] ctl_count_0, ctl_count_1;
  logic [7:0] tr_lat;
  int n_errors, samples_checked, i, k;
  drb_row_t rows [20] = '{
    '{1'b1, 2'h3, 16'h2000, 1'b0, 16'h0000},
    '{1'b1, 2'h1, 16'h8001, 1'b0, 16'h0000},
    '{1'b1, 2'h1, 16'h0002, 1'b1, 16'h0000},
    '{1'b1, 2'h2, 16'h00a5, 1'b1, 16'h0000},
    '{1'b1, 2'h2, 16'h00a6, 1'b1, 16'h0000},
    '{1'b0, 2'h3, 16'h0000, 1'b0, 16'h2001},
    '{1'b0, 2'h1, 16'h0000, 1'b0, 16'h8001},
    '{1'b0, 2'h1, 16'h0000, 1'b0, 16'h0002},
    '{1'b0, 2'h2, 16'h0000, 1'b0, 16'h00a5},
    '{1'b1, 2'h3, 16'h3000, 1'b0, 16'h0000},
    '{1'b0, 2'h3, 16'h0000, 1'b0, 16'h3002},
    '{1'b1, 2'h3, 16'h7000, 1'b0, 16'h0000},
    '{1'b0, 2'h3, 16'h0000, 1'b0, 16'h7001},
    '{1'b0, 2'h1, 16'h0000, 1'b0, 16'h00a6},
    '{1'b1, 2'h2, 16'h0777, 1'b0, 16'h0000},
    '{1'b1, 2'h3, 16'h5000, 1'b0, 16'h0000},
    '{1'b0, 2'h2, 16'h0000, 1'b0, 16'h0000},
    '{1'b1, 2'h3, 16'h7000, 1'b0, 16'h0000},
    '{1'b0, 2'h2, 16'h0000, 1'b0, 16'h0777},
    '{1'b1, 2'h1, 16'h0bcd, 1'b0, 16'h0000}
  };
  // ==================================================================
  // design and far-side controller
  drb_host_port i_drb_host_port (.mclk(mclk), .rst_n(rst_n), .bus_io_reset(bus_io_reset),
    .dev_code(dev_code), .host_port(host_port), .host_wr(host_wr), .host_rd(host_rd),
    .host_p(host_p), .host_wdata(host_wdata), .host_rdata_reg(host_rdata_reg), .ctl_rd(ctl_rd),
    .ctl_mem(ctl_mem), .ctl_reply_take(ctl_reply_take), .ctl_tr_done(ctl_tr_done),
    .ctl_rdata_reg(ctl_rdata_reg), .ctl_rvalid_reg(ctl_rvalid_reg), .ctl_reinit_reg(ctl_reinit_reg),
    .target_reset_reg(target_reset_reg), .pri_sel_reg(pri_sel_reg), .ctl_count_0(ctl_count_0),
    .ctl_count_1(ctl_count_1));
  drb_ctl_model i_drb_ctl_model (.mclk(mclk), .rst_n(rst_n), .target_reset_reg(target_reset_reg),
    .ctl_reinit_reg(ctl_reinit_reg), .tr_lat(tr_lat), .take_req(take_req), .take_mem(take_mem),
    .ctl_rd(ctl_rd), .ctl_mem(ctl_mem), .ctl_reply_take(ctl_reply_take), .ctl_tr_done(ctl_tr_done),
    .reinit_seen());
  // ==================================================================
  // tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      n_errors++;
    end
  endtask
  task automatic acc(input logic wr, input logic [1:0] port, input logic [15:0] d, input logic p,
                     output logic [15:0] rd);
    @(posedge mclk);
    host_wr <= wr;
    host_rd <= ~wr;
    host_port <= port;
    host_wdata <= d;
    host_p <= p & wr;
    @(posedge mclk);
    host_wr <= 1'b0;
    host_rd <= 1'b0;
    host_p <= 1'b0;
    host_port <= 2'b00;
    host_wdata <= ~d;
    #1 rd = host_rdata_reg;
  endtask
  task automatic ioreset();
    @(posedge mclk);
    bus_io_reset <= 1'b1;
    @(posedge mclk);
    bus_io_reset <= 1'b0;
    #1 chk({4'h0, ctl_count_0 | ctl_count_1}, 16'h0000, "counters after io reset");
    chk({15'h0, ctl_reinit_reg}, 16'h0001, "reinit request");
  endtask
  task automatic give_verdict();
    $display("errors %0d, checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ==================================================================
  // clock, watchdog, main sequence
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  initial begin
    #(40 * 10000);
    n_errors++;
    give_verdict();
  end
  initial begin
    {rst_n, bus_io_reset, host_wr, host_rd, host_p, take_req, take_mem} = 7'h00;
    dev_code = 6'h26;
    host_port = 2'b00;
    host_wdata = 16'h0000;
    tr_lat = 8'h00;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    #1 chk({target_reset_reg, pri_sel_reg, ctl_count_0, 2'b00}, 16'h0000, "reset state");
    for (i = 0; i < 20; i++) begin
      acc(rows[i].wr, rows[i].port, rows[i].d, rows[i].p, q);
      if (!rows[i].wr) chk(q, rows[i].exp, "row read");
    end
    // controller consumes one reply from physical memory 1
    @(posedge mclk);
    take_req <= 1'b1;
    take_mem <= 1'b1;
    @(posedge mclk);
    take_req <= 1'b0;
    @(posedge mclk);
    #1 chk({3'h0, ctl_rvalid_reg, ctl_count_1}, 16'h1001, "controller take");
    chk(ctl_rdata_reg, 16'h0bcd, "controller word, memory 1");
    // another device code must be ignored, P included
    @(posedge mclk);
    dev_code <= 6'h25;
    acc(1'b0, 2'h3, 16'h0000, 1'b0, q);
    chk(q, 16'h0000, "foreign status read");
    acc(1'b1, 2'h2, 16'h1111, 1'b1, q);
    chk({4'h0, ctl_count_0}, 16'h0001, "foreign write counted");
    @(posedge mclk);
    dev_code <= 6'h26;
    // target reset with a prompt and a slow controller
    for (k = 0; k < 2; k++) begin
      @(posedge mclk);
      tr_lat <= (k == 0) ? 8'h00 : 8'h1e;
      acc(1'b1, 2'h3, 16'ha000, 1'b0, q);
      chk({15'h0, target_reset_reg}, 16'h0001, "target reset set");
      done = 1'b0;
      for (i = 0; i < 40 && !done; i++) begin
        acc(1'b0, 2'h3, 16'h0000, 1'b0, q);
        done = (q[15] === 1'b0);
      end
      chk({15'h0, done}, 16'h0001, "target reset completion");
    end
    // io reset, then both address registers wrap on memory 0
    ioreset();
    for (i = 0; i < 1025; i++) acc(1'b1, 2'h1, i[15:0], 1'b0, q);
    for (i = 0; i < 1025; i++) begin
      acc(1'b0, 2'h1, 16'h0000, 1'b0, q);
      chk(q, (i % 1024 == 0) ? 16'h0400 : i[15:0], "wrap read");
    end
    // controller word from memory 0; its empty reply counter stays at zero
    @(posedge mclk);
    take_req <= 1'b1;
    take_mem <= 1'b0;
    @(posedge mclk);
    take_req <= 1'b0;
    @(posedge mclk);
    #1 chk(ctl_rdata_reg, 16'h0001, "controller word, memory 0");
    chk({3'h0, ctl_rvalid_reg, ctl_count_0}, 16'h1000, "take at zero count");
    // host and controller read memory 0 in one cycle: the host wins
    @(posedge mclk);
    take_req <= 1'b1;
    acc(1'b0, 2'h1, 16'h0000, 1'b0, q);
    chk(q, 16'h0002, "host read beside controller");
    chk({15'h0, ctl_rvalid_reg}, 16'h0000, "controller refused");
    @(posedge mclk);
    take_req <= 1'b0;
    repeat (3) @(posedge mclk);
    give_verdict();
  end
endmodule
